/* logic/offline_frame_search_pkg.sv */
package offline_frame_search_pkg;

	// register offset and field positions of the search status register
	localparam logic [7:0] OFFLINE_SEARCH_STATUS_ADDR = 8'h17;
	localparam int         STAT_DIRECTION_BIT         = 0;
	localparam int         STAT_ACTIVE_BIT            = 1;
	localparam int         STAT_TIMEOUT_BIT           = 2;
	localparam int         STAT_FOUND_BIT             = 3;
	localparam int         STAT_INVALID_BIT           = 4;
	localparam logic [7:0] STATUS_RESET               = 8'h00;

	// clock rate and timeout intervals
	localparam longint CLK_HZ        = 20000000;
	localparam longint T1_SF_TMO_US  = 12000;
	localparam longint T1_ESF_TMO_US = 24000;
	localparam longint E1_TMO_US     = 8000;
	localparam longint FORCE_TMO_US  = 24000;
	// all times round down to whole cycles
	localparam longint T1_SF_TMO_CYC  = (T1_SF_TMO_US * CLK_HZ) / 1000000;
	localparam longint T1_ESF_TMO_CYC = (T1_ESF_TMO_US * CLK_HZ) / 1000000;
	localparam longint E1_TMO_CYC     = (E1_TMO_US * CLK_HZ) / 1000000;
	localparam longint FORCE_TMO_CYC  = (FORCE_TMO_US * CLK_HZ) / 1000000;

	// framing mode families that select the timeout
	typedef enum logic [1:0] {
		MODE_T1_SF  = 2'h0,
		MODE_T1_ESF = 2'h1,
		MODE_E1     = 2'h2
	} framing_mode_type;

	// engine states, one-hot
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b01,
		ST_SEARCH = 2'b10
	} search_state_type;

	// search result strobes from the candidate comparator
	typedef struct packed {
		logic found;
		logic no_candidate;
		logic fas_aligned;
		logic mfas_aligned;
		logic cas_aligned;
	} search_result_type;

	// timebase realign pulses
	typedef struct packed {
		logic rx;
		logic tx;
		logic tx_system_bus_timebase;
	} realign_type;

endpackage

/* logic/offline_frame_search.sv */
`timescale 1ns/1ps
`default_nettype none
module offline_frame_search
	import offline_frame_search_pkg::*;
#(
	parameter longint T1_SF_CYCLES  = T1_SF_TMO_CYC,
	parameter longint T1_ESF_CYCLES = T1_ESF_TMO_CYC,
	parameter longint E1_CYCLES     = E1_TMO_CYC,
	parameter longint FORCE_CYCLES  = FORCE_TMO_CYC
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              rx_forced_reframe,
	input  wire logic              tx_forced_reframe,
	input  wire logic              rx_loss_of_frame_request,
	input  wire logic              tx_loss_of_frame_request,
	input  wire logic              rx_search_abort,
	input  wire logic              tx_search_abort,
	input  wire framing_mode_type  rx_mode,
	input  wire framing_mode_type  tx_mode,
	input  wire logic              tx_embedded_tsb,
	input  wire search_result_type result,
	input  wire logic [7:0]        rd_addr,
	output logic [7:0]             rd_data,
	output logic                   rx_force_clear,
	output logic                   tx_force_clear,
	output logic                   rx_lof_clear,
	output logic                   tx_lof_clear,
	output realign_type            realign,
	output logic                   realign_no_cofa,
	output logic                   fas_red_status,
	output logic                   mfas_red_status,
	output logic                   cas_red_status,
	output logic                   search_active
);

	// an idle engine takes the first pending request, receive before
	// transmit, and searches that direction until one event ends it:
	// found, no candidate, timeout, or the abort of that direction.
	// outcome flags clear on entry and are set by the ending event, so
	// a pending loss request may wipe them one cycle later; pollers that
	// must not miss an outcome watch the pulses rather than the status.
	// the engine never touches the loss flags itself: it only pulses a
	// clear towards the online framer that owns them.
	//
	// limitations: the window counter is 32 bits wide, ample for the
	// longest window at the line clock; window parameters must be at
	// least one cycle. a forced search always uses the forced window,
	// even when the mode window would be shorter.
	// trade-off: all outputs are registered, so every answer lags the
	// deciding edge by one cycle; the framers are built to expect that.

	// engine state and the context captured when a search begins
	search_state_type state_reg;
	logic             direction_reg;
	logic             forced_reg;
	logic             timeout_reg;
	logic             found_reg;
	logic             invalid_reg;
	logic [31:0]      count_reg;

	// window length of the running search
	logic [31:0]      mode_limit;
	logic [31:0]      limit_next;
	logic [31:0]      last_count;

	// requests after retiring those already answered
	logic             rx_lof_live;
	logic             tx_lof_live;
	logic             rx_req;
	logic             tx_req;

	// search entry
	logic             idle;
	logic             searching;
	logic             start;
	logic             start_dir;
	logic             start_forced;

	// events that may end a running search
	logic             abort_now;
	logic             expired;
	logic             hit_found;
	logic             hit_none;
	logic             hit_timeout;
	logic             finish;

	// success split by direction
	logic             rx_success;
	logic             tx_success;

	// receive search in e1 mode, the only case with red status
	logic             e1_rx_search;
	framing_mode_type cur_mode;

	// status word as the processor sees it
	logic [7:0]       status_word;

	// state decode shared by every registered process below
	assign idle      = (state_reg == ST_IDLE);
	assign searching = (state_reg == ST_SEARCH);

	// a loss request whose clear pulse is in flight is already answered;
	// the framer drops it one cycle late, so without this mask a stale
	// request would launch a pointless second search
	assign rx_lof_live = rx_loss_of_frame_request & ~rx_lof_clear;
	assign tx_lof_live = tx_loss_of_frame_request & ~tx_lof_clear;

	// a forced reframe and a loss request both ask for a search of that direction
	assign rx_req = rx_forced_reframe | rx_lof_live;
	assign tx_req = tx_forced_reframe | tx_lof_live;

	// receive wins when both directions ask at once; the other waits its turn
	assign start        = idle && (rx_req || tx_req);
	assign start_dir    = rx_req;
	assign start_forced = start_dir ? rx_forced_reframe : tx_forced_reframe;

	// mode and abort follow the searched direction; the other abort is ignored
	assign cur_mode  = direction_reg ? rx_mode : tx_mode;
	assign abort_now = direction_reg ? rx_search_abort : tx_search_abort;

	// counter runs 0 to limit-1, so the window is exactly limit cycles long
	assign last_count = limit_next - 32'h1;
	assign expired    = (count_reg >= last_count);

	// ending events in priority order: found, no candidate, abort, then timeout
	assign hit_found   = searching && result.found;
	assign hit_none    = searching && !result.found && result.no_candidate;
	assign hit_timeout = searching && !result.found && !result.no_candidate && !abort_now && expired;
	assign finish      = searching && (result.found || result.no_candidate || abort_now || expired);

	// success in each direction drives the loss clear and the realign
	assign rx_success = hit_found && direction_reg;
	assign tx_success = hit_found && !direction_reg;

	// red status only while a receive search runs in an e1 mode
	assign e1_rx_search = searching && direction_reg && (rx_mode == MODE_E1);

	// timeout length follows the framing mode of the searched direction
	always_comb begin
		unique case (cur_mode)
			MODE_T1_SF:  mode_limit = 32'(T1_SF_CYCLES);
			MODE_T1_ESF: mode_limit = 32'(T1_ESF_CYCLES);
			MODE_E1:     mode_limit = 32'(E1_CYCLES);
			// the spare code falls back to the longest mode window
			default:     mode_limit = 32'(T1_ESF_CYCLES);
		endcase
	end

	// a forced reframe runs one fixed window whatever the mode
	always_comb begin
		if (forced_reg) begin
			limit_next = 32'(FORCE_CYCLES);
		end else begin
			limit_next = mode_limit;
		end
	end

	// engine state; the search ends on the first terminating event
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (start) begin
						state_reg <= ST_SEARCH;
					end
				end
				ST_SEARCH: begin
					if (finish) begin
						state_reg <= ST_IDLE;
					end
				end
				// a corrupted code returns to idle rather than locking up
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// window counter: held at zero in idle, one step per searching cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_reg <= 32'h0;
		end else if (searching) begin
			count_reg <= count_reg + 32'h1;
		end else begin
			count_reg <= 32'h0;
		end
	end

	// direction and forced flag are captured only on search entry, so the
	// status keeps the last searched direction after the search ends
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			direction_reg <= 1'b0;
			forced_reg    <= 1'b0;
		end else if (start) begin
			direction_reg <= start_dir;
			forced_reg    <= start_forced;
		end
	end

	// forced request bits self-clear on entry; loss flags are left alone,
	// since a forced search must not hide a real loss of frame
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_force_clear <= 1'b0;
			tx_force_clear <= 1'b0;
		end else begin
			rx_force_clear <= start && start_dir && rx_forced_reframe;
			tx_force_clear <= start && !start_dir && tx_forced_reframe;
		end
	end

	// timeout flag: cleared on entry, latched when the window runs out
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			timeout_reg <= 1'b0;
		end else if (start) begin
			timeout_reg <= 1'b0;
		end else if (hit_timeout) begin
			timeout_reg <= 1'b1;
		end
	end

	// found flag: one only when a single candidate survived
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			found_reg <= 1'b0;
		end else if (start) begin
			found_reg <= 1'b0;
		end else if (hit_found) begin
			found_reg <= 1'b1;
		end
	end

	// no-candidate flag: set only when every candidate was eliminated
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			invalid_reg <= 1'b0;
		end else if (start) begin
			invalid_reg <= 1'b0;
		end else if (hit_none) begin
			invalid_reg <= 1'b1;
		end
	end

	// on success the requester's loss flag is cleared by its online framer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_lof_clear <= 1'b0;
			tx_lof_clear <= 1'b0;
		end else begin
			rx_lof_clear <= rx_success;
			tx_lof_clear <= tx_success;
		end
	end

	// realign the searched timebase; a transmit search with embedded
	// framing realigns the system bus timebase instead
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			realign <= '0;
		end else begin
			realign.rx  <= rx_success;
			realign.tx  <= tx_success && !tx_embedded_tsb;
			realign.tx_system_bus_timebase <= tx_success && tx_embedded_tsb;
		end
	end

	// masks the change-of-alignment detector for this realign only, so a
	// found pulse that moves the receive timebase is not counted as a change
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			realign_no_cofa <= 1'b0;
		end else begin
			realign_no_cofa <= rx_success;
		end
	end

	// intermediate red status, one bit per alignment level still missing;
	// it drops as soon as the search ends, whatever the outcome
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fas_red_status  <= 1'b0;
			mfas_red_status <= 1'b0;
			cas_red_status  <= 1'b0;
		end else begin
			fas_red_status  <= e1_rx_search && !result.fas_aligned;
			mfas_red_status <= e1_rx_search && !result.mfas_aligned;
			cas_red_status  <= e1_rx_search && !result.cas_aligned;
		end
	end

	// registered copy of the searching state for the framers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			search_active <= 1'b0;
		end else begin
			search_active <= searching;
		end
	end

	// status word; bits 7 to 5 stay zero
	always_comb begin
		status_word                     = 8'h00;
		status_word[STAT_DIRECTION_BIT] = direction_reg;
		status_word[STAT_ACTIVE_BIT]    = searching;
		status_word[STAT_TIMEOUT_BIT]   = timeout_reg;
		status_word[STAT_FOUND_BIT]     = found_reg;
		status_word[STAT_INVALID_BIT]   = invalid_reg;
	end

	// status readback is pure: a read never clears a flag, and the short
	// lived outcome bits can be missed by a slow poll
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data <= STATUS_RESET;
		end else if (rd_addr == OFFLINE_SEARCH_STATUS_ADDR) begin
			rd_data <= status_word;
		end else begin
			rd_data <= 8'h00;
		end
	end

endmodule
`default_nettype wire

/* tb/offline_frame_search_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module offline_frame_search_monitor
	import offline_frame_search_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [7:0]  rd_addr,
	input wire logic [7:0]  rd_data,
	input wire logic        rx_force_clear,
	input wire logic        tx_force_clear,
	input wire logic        rx_lof_clear,
	input wire logic        tx_lof_clear,
	input wire realign_type realign,
	input wire logic        realign_no_cofa,
	input wire logic        fas_red_status,
	input wire logic        mfas_red_status,
	input wire logic        cas_red_status,
	input wire logic        search_active
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_force_ack; (rx_force_clear || tx_force_clear) |-> !search_active ##1 search_active; endproperty
	a_force_ack: assert property (p_force_ack) else $error("force ack without entry");
	property p_force_pulse; (rx_force_clear || tx_force_clear) |=> !(rx_force_clear || tx_force_clear); endproperty
	a_force_pulse: assert property (p_force_pulse) else $error("force ack too long");
	property p_rsv_zero; rd_data[7:5] == 3'h0; endproperty
	a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits set");
	property p_unmapped; $past(rd_addr) != OFFLINE_SEARCH_STATUS_ADDR |-> rd_data == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
	property p_rx_found; rx_lof_clear |-> realign.rx && realign_no_cofa; endproperty
	a_rx_found: assert property (p_rx_found) else $error("rx found without realign");
	property p_tx_found; tx_lof_clear |-> (realign.tx || realign.tx_system_bus_timebase) && !realign_no_cofa; endproperty
	a_tx_found: assert property (p_tx_found) else $error("tx found without realign");
	property p_red_gate; (fas_red_status || mfas_red_status || cas_red_status) |-> search_active; endproperty
	a_red_gate: assert property (p_red_gate) else $error("red status while idle");
	property p_one_dir; realign.rx |-> !realign.tx && !realign.tx_system_bus_timebase; endproperty
	a_one_dir: assert property (p_one_dir) else $error("two directions realigned");
endmodule
`default_nettype wire

/* tb/offline_frame_search_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// processor and online framers; bits are rx force, tx force, rx loss, tx loss
module offline_frame_search_partner (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [3:0] set_req,
	input  wire logic [3:0] clr_req,
	output logic      [3:0] req_reg
);
	// a force holds until acked, a loss until found clears it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			req_reg <= 4'h0;
		end else begin
			req_reg <= (req_reg & ~clr_req) | set_req;
		end
	end
endmodule
`default_nettype wire

/* tb/offline_frame_search_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module offline_frame_search_tb
	import offline_frame_search_pkg::*;
;
	logic              clk, rst, ab_rx, ab_tx, emb, rfc, tfc, rlc, tlc, nc, fr, mr, cr, act;
	logic [3:0]        set_r, req;
	logic [7:0]        ra, rd;
	framing_mode_type  rxm, txm;
	search_result_type res;
	realign_type       rl;
	int                err_count, tests_run, n;
	int                lim[3] = '{20, 30, 25};
	offline_frame_search_partner u_offline_frame_search_partner (.clk(clk), .rst(rst), .set_req(set_r),
		.clr_req({tlc, rlc, tfc, rfc}), .req_reg(req));
	offline_frame_search #(.T1_SF_CYCLES(20), .T1_ESF_CYCLES(30), .E1_CYCLES(25), .FORCE_CYCLES(40))
	u_offline_frame_search (.clk(clk), .rst(rst), .rx_forced_reframe(req[0]), .tx_forced_reframe(req[1]),
		.rx_loss_of_frame_request(req[2]), .tx_loss_of_frame_request(req[3]), .rx_search_abort(ab_rx),
		.tx_search_abort(ab_tx), .rx_mode(rxm), .tx_mode(txm), .tx_embedded_tsb(emb), .result(res),
		.rd_addr(ra), .rd_data(rd), .rx_force_clear(rfc), .tx_force_clear(tfc), .rx_lof_clear(rlc),
		.tx_lof_clear(tlc), .realign(rl), .realign_no_cofa(nc), .fas_red_status(fr),
		.mfas_red_status(mr), .cas_red_status(cr), .search_active(act));
	task automatic chk(input logic [7:0] s, input logic [7:0] e, input string nm);
		tests_run++;
		if (s !== e) begin
			err_count++;
			$display("wrong value %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#2;
	endtask
	// one-cycle pulse into the partner, which then holds the request
	task automatic go(input logic [3:0] s);
		set_r = s;
		step(1);
		set_r = 4'h0;
	endtask
	// comparator strobe; realign pulses are seen one cycle later only
	task automatic hit(input search_result_type r, input logic [7:0] e);
		res = r;
		step(1);
		res = '0;
		chk({4'h0, nc, rl}, e, "realign");
	endtask
	// outcome bits may stand one cycle only, so every cycle is looked at
	task automatic wait_bit(input int b, input int lo, input int hi);
		n = 0;
		while (rd[b] !== 1'b1 && n < 300) begin
			step(1);
			n++;
		end
		chk(8'(n >= lo && n <= hi), 8'h01, "timeout_len");
	endtask
	task automatic summarize;
		if (err_count == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// whole run is about two hundred cycles
	initial begin
		#1ms;
		err_count++;
		summarize();
	end
	initial begin
		{rst, ab_rx, ab_tx, emb, set_r, res} = '0;
		rst = 1'b1;
		rxm = MODE_T1_SF;
		txm = MODE_T1_SF;
		ra = OFFLINE_SEARCH_STATUS_ADDR;
		step(2);
		rst = 1'b0;
		step(1);
		chk(rd, STATUS_RESET, "reset");
		ra = 8'h16;
		step(2);
		chk(rd, 8'h00, "unmapped");
		ra = OFFLINE_SEARCH_STATUS_ADDR;
		go(4'h1);
		step(3);
		chk(rd, 8'h03, "rx_force");
		chk({4'h0, req}, 8'h00, "force_self_clear");
		hit(5'h10, 8'h0c);
		step(1);
		chk(rd, 8'h09, "found");
		go(4'h2);
		step(3);
		chk(rd, 8'h02, "tx_force");
		hit(5'h08, 8'h00);
		step(1);
		chk(rd, 8'h10, "no_cand");
		go(4'h2);
		ab_rx = 1'b1;
		step(3);
		chk(rd, 8'h02, "other_abort");
		{ab_rx, ab_tx} = 2'b01;
		step(1);
		ab_tx = 1'b0;
		step(2);
		chk(rd, 8'h00, "abort");
		go(4'h2);
		wait_bit(2, 39, 44);
		step(3);
		chk(rd, 8'h04, "timeout");
		emb = 1'b1;
		go(4'h2);
		step(3);
		hit(5'h10, 8'h01);
		for (int m = 0; m < 3; m++) begin
			rxm = framing_mode_type'(m[1:0]);
			go(4'h4);
			wait_bit(2, lim[m] - 1, lim[m] + 4);
			step(3);
			chk(rd, 8'h03, "restart");
			chk({5'h0, fr, mr, cr}, (m == 2) ? 8'h07 : 8'h00, "red");
			hit(5'h10, 8'h0c);
			step(1);
			chk({4'h0, req}, 8'h00, "lof_cleared");
		end
		txm = framing_mode_type'(2'h3);
		go(4'h8);
		wait_bit(2, 29, 34);
		step(3);
		chk(rd, 8'h02, "tx_restart");
		hit(5'h10, 8'h01);
		step(1);
		chk({4'h0, req}, 8'h00, "tx_lof_cleared");
		summarize();
	end
endmodule
bind offline_frame_search offline_frame_search_monitor u_offline_frame_search_monitor (.clk(clk), .rst(rst),
	.rd_addr(rd_addr), .rd_data(rd_data), .rx_force_clear(rx_force_clear), .tx_force_clear(tx_force_clear),
	.rx_lof_clear(rx_lof_clear), .tx_lof_clear(tx_lof_clear), .realign(realign), .realign_no_cofa(realign_no_cofa),
	.fas_red_status(fas_red_status), .mfas_red_status(mfas_red_status), .cas_red_status(cas_red_status),
	.search_active(search_active));
`default_nettype wire
